// >>> shared/irc_pkg.sv
/*
 Constants for the interrupt request classifier: address window, field
 positions of the interrupt message address, and the result codes.
 Assumes a 32-bit request address and a 16-bit requester identifier.
*/
package irc_pkg;
	localparam int          ADDR_W        = 32;
	localparam int          SID_W         = 16;
	localparam int          HANDLE_W      = 16;
	localparam int          WIN_HI        = 31;
	localparam int          WIN_LO        = 20;
	localparam logic [11:0] WIN_VALUE     = 12'hFEE;
	localparam int          FMT_BIT       = 4;
	localparam int          HLO_HI        = 19;
	localparam int          HLO_LO        = 5;
	localparam int          HHI_BIT       = 2;
	localparam logic [3:0]  DW_LEN        = 4'h1;
	localparam logic [SID_W-1:0] SID_ZERO = 16'h0000;

	// Request kinds presented by the upstream transaction decoder
	typedef enum logic [1:0] {
		IRC_KIND_WRITE  = 2'h0,
		IRC_KIND_READ   = 2'h1,
		IRC_KIND_ATOMIC = 2'h2
	} irc_kind_t;

	// Outcome of classification
	typedef enum logic [1:0] {
		IRC_RES_PASS    = 2'h0,
		IRC_RES_INTR    = 2'h1,
		IRC_RES_UR      = 2'h2,
		IRC_RES_LOCAL   = 2'h3
	} irc_res_t;
endpackage

// >>> logic/irc_classifier.sv
/*
 Interrupt request classifier: sits at the upstream write path of the
 root complex, recognises interrupt writes, attaches source identity and
 format, and flags unsupported accesses to the interrupt window.
 Assumes one request per cycle from logic on clock_i; own fault and
 invalidation events enter on a separate local port.
*/
`timescale 1ns/1ps
module irc_classifier #(
	parameter bit REMAP_SUPPORTED = 1'b1
) (
	// Clock and reset
	input  wire logic                        clock_i,
	input  wire logic                        rst_n_i,
	// Upstream request
	input  wire logic                        req_valid_i,
	input  wire logic [1:0]                  req_kind_i,
	input  wire logic                        req_translated_i,
	input  wire logic [3:0]                  req_len_i,
	input  wire logic [irc_pkg::ADDR_W-1:0]  req_addr_i,
	input  wire logic [irc_pkg::SID_W-1:0]   req_rid_i,
	// Locally generated events (fault, invalidation completion)
	input  wire logic                        local_valid_i,
	input  wire logic [irc_pkg::ADDR_W-1:0]  local_addr_i,
	// Capability
	output logic                             cap_remap_o,
	// Classified result
	output logic                             out_valid_o,
	output logic [1:0]                       out_res_o,
	output logic                             out_remap_fmt_o,
	output logic [irc_pkg::SID_W-1:0]        out_sid_o,
	output logic [irc_pkg::HANDLE_W-1:0]     out_handle_o,
	output logic [irc_pkg::ADDR_W-1:0]       out_addr_o
);
	logic rst_meta_reg;
	logic rst_sync_reg;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	wire rst_n = rst_sync_reg;

	// Decode
	wire in_window = req_addr_i[irc_pkg::WIN_HI:irc_pkg::WIN_LO]
		== irc_pkg::WIN_VALUE;
	wire is_write  = req_kind_i == irc_pkg::IRC_KIND_WRITE;
	wire is_read   = req_kind_i == irc_pkg::IRC_KIND_READ;
	wire is_atomic = req_kind_i == irc_pkg::IRC_KIND_ATOMIC;
	wire fmt_bit   = req_addr_i[irc_pkg::FMT_BIT];
	wire is_intr   = in_window && is_write && !req_translated_i
		&& req_len_i == irc_pkg::DW_LEN;
	wire is_ur     = in_window && (is_read
		|| (req_translated_i && (is_write || is_atomic))
		|| (is_write && req_len_i != irc_pkg::DW_LEN)
		|| (is_intr && fmt_bit && !REMAP_SUPPORTED));
	wire [irc_pkg::HANDLE_W-1:0] handle = {
		req_addr_i[irc_pkg::HHI_BIT],
		req_addr_i[irc_pkg::HLO_HI:irc_pkg::HLO_LO]};
	wire [1:0] res_next = is_ur ? irc_pkg::IRC_RES_UR
		: is_intr ? irc_pkg::IRC_RES_INTR : irc_pkg::IRC_RES_PASS;
	wire remap_next = is_intr && fmt_bit;

	assign cap_remap_o = REMAP_SUPPORTED;

	// Local events take priority and never enter the remap path
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			out_valid_o     <= 1'b0;
			out_res_o       <= irc_pkg::IRC_RES_PASS;
			out_remap_fmt_o <= 1'b0;
			out_sid_o       <= irc_pkg::SID_ZERO;
			out_handle_o    <= '0;
			out_addr_o      <= '0;
		end else if (local_valid_i) begin
			out_valid_o     <= 1'b1;
			out_res_o       <= irc_pkg::IRC_RES_LOCAL;
			out_remap_fmt_o <= 1'b0;
			out_sid_o       <= irc_pkg::SID_ZERO;
			out_handle_o    <= '0;
			out_addr_o      <= local_addr_i;
		end else begin
			out_valid_o     <= req_valid_i;
			out_res_o       <= res_next;
			out_remap_fmt_o <= remap_next;
			// Requester id taken as given, aliases included
			out_sid_o       <= req_rid_i;
			out_handle_o    <= remap_next ? handle : '0;
			out_addr_o      <= req_addr_i;
		end
	end

	// Remappable result only when supported
	property p_fmt_supported;
		@(posedge clock_i) disable iff (!rst_n)
		out_valid_o && out_res_o == irc_pkg::IRC_RES_INTR && out_remap_fmt_o
			|-> REMAP_SUPPORTED;
	endproperty
	a_fmt_supported: assert property (p_fmt_supported)
		else $error("remappable interrupt without support");

	property p_window_intr;
		@(posedge clock_i) disable iff (!rst_n)
		req_valid_i && !local_valid_i && is_write && !req_translated_i
			&& req_len_i == irc_pkg::DW_LEN && in_window
			&& (!fmt_bit || REMAP_SUPPORTED)
			|=> out_valid_o && out_res_o == irc_pkg::IRC_RES_INTR;
	endproperty
	a_window_intr: assert property (p_window_intr)
		else $error("window write not classified as interrupt");

	property p_read_ur;
		@(posedge clock_i) disable iff (!rst_n)
		req_valid_i && !local_valid_i && is_read && in_window
			|=> out_res_o == irc_pkg::IRC_RES_UR;
	endproperty
	a_read_ur: assert property (p_read_ur)
		else $error("window read not answered unsupported");

	property p_xlat_ur;
		@(posedge clock_i) disable iff (!rst_n)
		req_valid_i && !local_valid_i && in_window && req_translated_i
			&& (is_write || is_atomic) |=> out_res_o == irc_pkg::IRC_RES_UR;
	endproperty
	a_xlat_ur: assert property (p_xlat_ur)
		else $error("translated window access not unsupported");

	property p_sid;
		@(posedge clock_i) disable iff (!rst_n)
		req_valid_i && !local_valid_i |=> out_sid_o == $past(req_rid_i);
	endproperty
	a_sid: assert property (p_sid)
		else $error("source id not taken from requester id");

	property p_fmt;
		@(posedge clock_i) disable iff (!rst_n)
		req_valid_i && !local_valid_i && is_intr
			|=> out_remap_fmt_o == $past(req_addr_i[irc_pkg::FMT_BIT]);
	endproperty
	a_fmt: assert property (p_fmt)
		else $error("format bit misclassified");

	property p_handle;
		@(posedge clock_i) disable iff (!rst_n)
		out_valid_o && out_remap_fmt_o |->
			out_handle_o == {out_addr_o[irc_pkg::HHI_BIT],
			out_addr_o[irc_pkg::HLO_HI:irc_pkg::HLO_LO]};
	endproperty
	a_handle: assert property (p_handle)
		else $error("handle does not match address");

	property p_local;
		@(posedge clock_i) disable iff (!rst_n)
		local_valid_i |=> out_valid_o && !out_remap_fmt_o
			&& out_res_o == irc_pkg::IRC_RES_LOCAL;
	endproperty
	a_local: assert property (p_local)
		else $error("local event entered remap path");

	property p_local_clean;
		@(posedge clock_i) disable iff (!rst_n)
		local_valid_i |=> out_sid_o == irc_pkg::SID_ZERO
			&& out_handle_o == '0 && out_addr_o == $past(local_addr_i);
	endproperty
	a_local_clean: assert property (p_local_clean)
		else $error("local event carries request fields");

	property p_nofmt_ur;
		@(posedge clock_i) disable iff (!rst_n)
		req_valid_i && !local_valid_i && is_intr && fmt_bit
			&& !REMAP_SUPPORTED |=> out_res_o == irc_pkg::IRC_RES_UR;
	endproperty
	a_nofmt_ur: assert property (p_nofmt_ur)
		else $error("remappable request accepted without support");

	property p_pass_outside;
		@(posedge clock_i) disable iff (!rst_n)
		req_valid_i && !local_valid_i && !in_window
			|=> out_valid_o && out_res_o == irc_pkg::IRC_RES_PASS;
	endproperty
	a_pass_outside: assert property (p_pass_outside)
		else $error("request outside window not passed");

	property p_long_ur;
		@(posedge clock_i) disable iff (!rst_n)
		req_valid_i && !local_valid_i && in_window && is_write
			&& req_len_i != irc_pkg::DW_LEN |=> out_res_o == irc_pkg::IRC_RES_UR;
	endproperty
	a_long_ur: assert property (p_long_ur)
		else $error("multi-doubleword window write not unsupported");

	property p_compat_handle;
		@(posedge clock_i) disable iff (!rst_n)
		out_valid_o && !out_remap_fmt_o
			|-> out_handle_o == '0;
	endproperty
	a_compat_handle: assert property (p_compat_handle)
		else $error("compatibility result carries a handle");

	property p_valid_pulse;
		@(posedge clock_i) disable iff (!rst_n)
		!req_valid_i && !local_valid_i
			|=> !out_valid_o;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse)
		else $error("result valid without a request");
endmodule

// >>> sim/irc_far_end.sv
/*
 Far-end requester model: endpoint, bridge or interrupt controller.
 Assumes the bench calls its tasks at a falling clock edge.
*/
`timescale 1ns/1ps
module irc_far_end (
	// Request lines
	output logic        req_valid_o,
	output logic [1:0]  req_kind_o,
	output logic        req_translated_o,
	output logic [3:0]  req_len_o,
	output logic [31:0] req_addr_o,
	output logic [15:0] req_rid_o
);
	initial begin
		req_valid_o = 1'b0;
		req_kind_o = 2'h0;
		req_translated_o = 1'b0;
		req_len_o = 4'h1;
		req_addr_o = 32'h0000_0000;
		req_rid_o = 16'h0000;
	end
	task automatic send(input logic [1:0] k, input logic t,
		input logic [3:0] n, input logic [31:0] a, input logic [15:0] r);
		req_valid_o = 1'b1;
		req_kind_o = k;
		req_translated_o = t;
		req_len_o = n;
		req_addr_o = a;
		req_rid_o = r;
	endtask
	// Released address and requester id lines show the inverse of the last value
	task automatic release_bus();
		req_valid_o = 1'b0;
		req_addr_o = ~req_addr_o;
		req_rid_o = ~req_rid_o;
	endtask
endmodule

// >>> sim/tb_interrupt_request_classifier.sv
/*
 Testbench for the interrupt request classifier.
 Assumes a one-cycle answer and the far-end model in irc_far_end.
*/
`timescale 1ns/1ps
module tb_interrupt_request_classifier;
	logic        clock_i, rst_n_i, req_valid_i, req_translated_i;
	logic        local_valid_i, cap_remap_o, out_valid_o, out_remap_fmt_o;
	logic [1:0]  req_kind_i, out_res_o;
	logic [3:0]  req_len_i;
	logic [31:0] req_addr_i, local_addr_i, out_addr_o;
	logic [15:0] req_rid_i, out_sid_o, out_handle_o;
	logic        nr_cap;
	logic [1:0]  nr_res;
	int          err_count = 0;
	int          n_tests = 0;
	irc_far_end irc_far_end_i (.req_valid_o(req_valid_i),
		.req_kind_o(req_kind_i), .req_translated_o(req_translated_i),
		.req_len_o(req_len_i), .req_addr_o(req_addr_i),
		.req_rid_o(req_rid_i));
	irc_classifier irc_classifier_i (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.req_valid_i(req_valid_i), .req_kind_i(req_kind_i),
		.req_translated_i(req_translated_i), .req_len_i(req_len_i),
		.req_addr_i(req_addr_i), .req_rid_i(req_rid_i),
		.local_valid_i(local_valid_i), .local_addr_i(local_addr_i),
		.cap_remap_o(cap_remap_o), .out_valid_o(out_valid_o),
		.out_res_o(out_res_o), .out_remap_fmt_o(out_remap_fmt_o),
		.out_sid_o(out_sid_o), .out_handle_o(out_handle_o),
		.out_addr_o(out_addr_o));
	// Same requests into a copy built without remapping support
	irc_classifier #(.REMAP_SUPPORTED(1'b0)) irc_classifier_nr_i (
		.clock_i(clock_i), .rst_n_i(rst_n_i),
		.req_valid_i(req_valid_i), .req_kind_i(req_kind_i),
		.req_translated_i(req_translated_i), .req_len_i(req_len_i),
		.req_addr_i(req_addr_i), .req_rid_i(req_rid_i),
		.local_valid_i(local_valid_i), .local_addr_i(local_addr_i),
		.cap_remap_o(nr_cap), .out_valid_o(), .out_res_o(nr_res),
		.out_remap_fmt_o(), .out_sid_o(), .out_handle_o(),
		.out_addr_o());
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end
	// Drive one request now, judge the answer one cycle later
	task automatic put(input logic [1:0] k, input logic t,
		input logic [3:0] n, input logic [31:0] a, input logic [15:0] r,
		input logic [1:0] res);
		logic f;
		f = (res == irc_pkg::IRC_RES_INTR) && a[4];
		irc_far_end_i.send(k, t, n, a, r);
		@(negedge clock_i);
		n_tests++;
		if (out_valid_o !== 1'b1 || out_res_o !== res || out_addr_o !== a
		 || out_remap_fmt_o !== f || (f == 1'b0 && out_handle_o !== 16'h0)
		 || (f && out_handle_o !== {a[2], a[19:5]})
		 || (res == irc_pkg::IRC_RES_INTR && out_sid_o !== r)
		 || nr_res !== (f ? 2'h2 : res)) begin
			err_count++;
			$display("wrong value at %0t: addr %h", $time, a);
		end
	endtask
	task automatic idle();
		irc_far_end_i.release_bus();
		@(negedge clock_i);
		n_tests++;
		if (out_valid_o !== 1'b0) begin
			err_count++;
			$display("wrong value at %0t: valid stands", $time);
		end
	endtask
	task automatic t_formats();
		put(2'h0, 1'b0, 4'h1, 32'hFEE0_0000, 16'h0108, 2'h1);
		put(2'h0, 1'b0, 4'h1, 32'hFEEF_FFF4, 16'h0500, 2'h1);
		put(2'h0, 1'b0, 4'h1, 32'hFEE5_5530, 16'hF0A5, 2'h1);
		idle();
	endtask
	task automatic t_refused();
		put(2'h1, 1'b0, 4'h1, 32'hFEE0_0010, 16'h0108, 2'h2);
		put(2'h0, 1'b1, 4'h1, 32'hFEE0_0010, 16'h0108, 2'h2);
		put(2'h2, 1'b1, 4'h1, 32'hFEE0_0000, 16'h0108, 2'h2);
		put(2'h0, 1'b0, 4'h2, 32'hFEE0_0000, 16'h0108, 2'h2);
		put(2'h0, 1'b0, 4'h1, 32'hFED0_0010, 16'h0108, 2'h0);
		put(2'h2, 1'b0, 4'h1, 32'hFEE0_0000, 16'h0108, 2'h0);
		idle();
	endtask
	task automatic t_local();
		local_valid_i = 1'b1;
		local_addr_i = 32'hFEE0_0018;
		irc_far_end_i.send(2'h0, 1'b0, 4'h1, 32'hFEE0_0000, 16'h0108);
		@(negedge clock_i);
		local_valid_i = 1'b0;
		n_tests++;
		if (out_res_o !== 2'h3 || out_remap_fmt_o !== 1'b0
		 || out_sid_o !== 16'h0 || out_addr_o !== 32'hFEE0_0018
		 || out_valid_o !== 1'b1 || out_handle_o !== 16'h0) begin
			err_count++;
			$display("wrong value at %0t: local event", $time);
		end
		idle();
	endtask
	// Mid-run reset with a result standing, then the first legal request
	task automatic t_reset();
		irc_far_end_i.send(2'h0, 1'b0, 4'h1, 32'hFEE0_0014, 16'h0108);
		@(negedge clock_i);
		rst_n_i = 1'b0;
		irc_far_end_i.release_bus();
		@(negedge clock_i);
		n_tests++;
		if (out_valid_o !== 1'b0 || out_sid_o !== 16'h0
		 || out_addr_o !== 32'h0) begin
			err_count++;
			$display("wrong value at %0t: reset", $time);
		end
		rst_n_i = 1'b1;
		repeat (2) @(negedge clock_i);
		put(2'h0, 1'b0, 4'h1, 32'hFEE0_0014, 16'h0108, 2'h1);
		idle();
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		rst_n_i = 1'b0;
		local_valid_i = 1'b0;
		local_addr_i = 32'h0000_0000;
		repeat (12) @(posedge clock_i);
		@(negedge clock_i);
		rst_n_i = 1'b1;
		repeat (3) @(negedge clock_i);
		n_tests++;
		if (cap_remap_o !== 1'b1 || nr_cap !== 1'b0) begin
			err_count++;
			$display("wrong value at %0t: capability", $time);
		end
		t_formats();
		t_refused();
		t_local();
		t_reset();
		print_verdict();
	end
endmodule
